// *** hdl/sector_guard_consts.vh ***
// Constants for the multi-level sector guard protection logic
// Functional notes
// - Protection mode register is 16 bits; only bits 2 and 1 act, rest reserved.
// - One volatile freeze bit guards all nonvolatile sector lock bits.
// - One nonvolatile lock bit per 128KB sector; locked until set back to 1.
// - One volatile lock bit set per 128KB sector, cleared on reset.
// - With 64KB sectors, lock bits still map to 128KB regions.
// - Password bit at 0 enables password mode forever; password never read or changed.
// - Plain bit at 0 allows lock changes without password; bit 2 stays 1.
// - Bits 2 and 1 are one-time programmable; at most one ever becomes 0.
// - In password mode, freeze bit goes 0 to 1 only with right password.
// - Wrong or missing password leaves freeze bit unchanged.
// - Nonvolatile lock bits are programmable and erasable in either mode, subject to freeze.
// - Delivered state: all sectors unlocked, mode bits at defaults.
// - Freeze at 1 allows lock program/erase; at 0 those commands are refused.
// - Freeze-bit read command returns the current freeze bit.
// - In password mode, freeze bit is forced to 0 on every reset.
// - Correct password unlock command sets the freeze bit to 1.
// - Freeze-bit write command clears the freeze bit to 0.
// - Nonvolatile lock bits program individually, erase only as a group.
// - Sector write-protect bit at 1 refuses program and erase in that sector.
// - Sector lock-down bit at 1 blocks writes to both volatile bits until reset.
// - Nonvolatile lock byte reads 00h protected, FFh unprotected.
`ifndef SECTOR_GUARD_CONSTS_VH
`define SECTOR_GUARD_CONSTS_VH
`define MODE_W 16
`define MODE_RESET 16'hffff
`define MODE_PW_BIT 2
`define MODE_PLAIN_BIT 1
`define FREEZE_W 8
`define FREEZE_BIT 0
`define PW_W 64
`define PW_RESET 64'hffffffffffffffff
`define SECT_W 8
`define NUM_SECT 256
`define ADDR_W 25
`define REGION_LSB 17
`define VLOCK_WP_BIT 0
`define VLOCK_LD_BIT 1
`define NVLOCK_LOCKED 8'h00
`define NVLOCK_OPEN 8'hff
`define CMD_W 4
`define CMD_NONE 4'h0
`define CMD_RD_MODE 4'h1
`define CMD_PG_MODE 4'h2
`define CMD_RD_FREEZE 4'h3
`define CMD_WR_FREEZE 4'h4
`define CMD_UNLOCK 4'h5
`define CMD_PG_PW 4'h6
`define CMD_RD_PW 4'h7
`define CMD_RD_NVLOCK 4'h8
`define CMD_PG_NVLOCK 4'h9
`define CMD_ER_NVLOCK 4'ha
`define CMD_RD_VLOCK 4'hb
`define CMD_WR_VLOCK 4'hc
`define CMD_CHK_ARRAY 4'hd
`endif

// *** hdl/lock_bit_array.v ***
// Per-sector nonvolatile lock bit store with registered read port
`include "sector_guard_consts.vh"
module lock_bit_array (
    // Clock
    input wire ref_clk,
    // Access
    input wire [`SECT_W-1:0] addr,
    input wire prog_en,
    input wire erase_all,
    // Read data
    output reg locked_ff
);
    reg [`NUM_SECT-1:0] open_ff;

    // Program clears one bit, erase returns every bit to 1; contents survive reset
    always @(posedge ref_clk) begin
        if (erase_all) begin
            open_ff <= {`NUM_SECT{1'b1}};
        end else if (prog_en) begin
            open_ff[addr] <= 1'b0;
        end
        locked_ff <= ~open_ff[addr];
    end

    // Delivered unlocked: stands in for the erased factory state
    initial begin
        open_ff = {`NUM_SECT{1'b1}};
    end
endmodule

// *** hdl/volatile_lock_bank.v ***
// Per-sector volatile write-protect and lock-down bits
`include "sector_guard_consts.vh"
module volatile_lock_bank (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Write port
    input wire [`SECT_W-1:0] addr,
    input wire wr_en,
    input wire [1:0] wr_data,
    // Status
    output wire [`NUM_SECT-1:0] wp_vec,
    output wire [`NUM_SECT-1:0] ld_vec
);
    genvar g;
    generate
        for (g = 0; g < `NUM_SECT; g = g + 1) begin : sect
            reg wp_ff;
            reg ld_ff;
            // Cleared on reset; frozen once lock-down is set
            always @(posedge ref_clk) begin
                if (rst) begin
                    wp_ff <= 1'b0;
                    ld_ff <= 1'b0;
                end else if (wr_en && addr == g && !ld_ff) begin
                    wp_ff <= wr_data[`VLOCK_WP_BIT];
                    ld_ff <= wr_data[`VLOCK_LD_BIT];
                end
            end
            assign wp_vec[g] = wp_ff;
            assign ld_vec[g] = ld_ff;
        end
    endgenerate
endmodule

// *** hdl/sector_password_protection.v ***
// Mode register, password, freeze bit and sector lock decision logic
`include "sector_guard_consts.vh"
module sector_password_protection (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Decoded protection command
    input wire cmd_valid,
    input wire [`CMD_W-1:0] cmd_op,
    input wire [`ADDR_W-1:0] cmd_addr,
    input wire [`PW_W-1:0] cmd_data,
    // Response
    output reg rsp_valid_ff,
    output reg [`PW_W-1:0] rsp_data_ff,
    output reg rsp_refused_ff,
    // Array operation check result
    output reg array_ok_ff,
    // Freeze bit level
    output wire freeze_open
);
    reg [`MODE_W-1:0] mode_ff;
    reg [`PW_W-1:0] pw_ff;
    reg freeze_ff;
    reg [`MODE_W-1:0] nxt_mode;
    reg [`PW_W-1:0] nxt_pw;
    reg nxt_freeze;
    reg nxt_refused;
    reg pend_rd_ff;
    reg pend_chk_ff;
    reg [`SECT_W-1:0] pend_sect_ff;
    wire [`SECT_W-1:0] sect;
    wire pw_mode;
    wire plain_mode;
    wire nv_allowed;
    wire nv_prog;
    wire nv_erase;
    wire nv_locked;
    wire [`NUM_SECT-1:0] wp_vec;
    wire [`NUM_SECT-1:0] ld_vec;

    // Region index from address: 128KB granularity also for 64KB sector parts
    function [`SECT_W-1:0] region_of;
        input [`ADDR_W-1:0] a;
        begin
            region_of = a[`REGION_LSB +: `SECT_W];
        end
    endfunction

    assign sect = region_of(cmd_addr);
    assign pw_mode = ~mode_ff[`MODE_PW_BIT];
    assign plain_mode = ~mode_ff[`MODE_PLAIN_BIT];
    assign freeze_open = freeze_ff;
    // Lock bits change in either mode, only while freeze is open
    assign nv_allowed = freeze_ff;
    assign nv_prog = cmd_valid && cmd_op == `CMD_PG_NVLOCK && nv_allowed;
    assign nv_erase = cmd_valid && cmd_op == `CMD_ER_NVLOCK && nv_allowed;

    lock_bit_array u_nv (
        .ref_clk(ref_clk),
        .addr(sect),
        .prog_en(nv_prog),
        .erase_all(nv_erase),
        .locked_ff(nv_locked)
    );

    volatile_lock_bank u_vl (
        .ref_clk(ref_clk),
        .rst(rst),
        .addr(sect),
        .wr_en(cmd_valid && cmd_op == `CMD_WR_VLOCK),
        .wr_data(cmd_data[1:0]),
        .wp_vec(wp_vec),
        .ld_vec(ld_vec)
    );

    // Next state of the mode register, password and freeze bit
    always @* begin
        nxt_mode = mode_ff;
        nxt_pw = pw_ff;
        nxt_freeze = freeze_ff;
        nxt_refused = 1'b0;
        if (cmd_valid) begin
            case (cmd_op)
                `CMD_PG_MODE: begin
                    // OTP: bits only go to 0, one of the two at most
                    if (pw_mode || plain_mode) begin
                        nxt_refused = 1'b1;
                    end else if (!cmd_data[`MODE_PW_BIT]) begin
                        nxt_mode[`MODE_PW_BIT] = 1'b0;
                    end else if (!cmd_data[`MODE_PLAIN_BIT]) begin
                        nxt_mode[`MODE_PLAIN_BIT] = 1'b0;
                    end
                end
                `CMD_PG_PW: begin
                    if (pw_mode) begin
                        nxt_refused = 1'b1;
                    end else begin
                        nxt_pw = cmd_data;
                    end
                end
                `CMD_WR_FREEZE: begin
                    nxt_freeze = 1'b0;
                end
                `CMD_UNLOCK: begin
                    // Full compare; without password mode freeze reopens freely
                    if (!pw_mode || cmd_data == pw_ff) begin
                        nxt_freeze = 1'b1;
                    end else begin
                        nxt_refused = 1'b1;
                    end
                end
                `CMD_PG_NVLOCK, `CMD_ER_NVLOCK: begin
                    nxt_refused = !nv_allowed;
                end
                `CMD_WR_VLOCK: begin
                    nxt_refused = ld_vec[sect];
                end
                default: begin
                    nxt_refused = 1'b0;
                end
            endcase
        end
    end

    // Nonvolatile mode and password survive reset; freeze reloads on reset
    always @(posedge ref_clk) begin
        mode_ff <= nxt_mode;
        pw_ff <= nxt_pw;
        if (rst) begin
            freeze_ff <= ~pw_mode;
        end else begin
            freeze_ff <= nxt_freeze;
        end
    end

    // Delivered state of the nonvolatile fields
    initial begin
        mode_ff = `MODE_RESET;
        pw_ff = `PW_RESET;
    end

    // Response register; lock array reads complete one cycle later
    always @(posedge ref_clk) begin
        if (rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= {`PW_W{1'b0}};
            rsp_refused_ff <= 1'b0;
            array_ok_ff <= 1'b0;
            pend_rd_ff <= 1'b0;
            pend_chk_ff <= 1'b0;
            pend_sect_ff <= {`SECT_W{1'b0}};
        end else begin
            pend_rd_ff <= cmd_valid && cmd_op == `CMD_RD_NVLOCK;
            pend_chk_ff <= cmd_valid && cmd_op == `CMD_CHK_ARRAY;
            pend_sect_ff <= sect;
            rsp_valid_ff <= 1'b0;
            rsp_refused_ff <= 1'b0;
            array_ok_ff <= 1'b0;
            if (pend_rd_ff) begin
                rsp_valid_ff <= 1'b1;
                rsp_data_ff <= {56'h0, nv_locked ? `NVLOCK_LOCKED : `NVLOCK_OPEN};
            end else if (pend_chk_ff) begin
                rsp_valid_ff <= 1'b1;
                array_ok_ff <= !nv_locked && !wp_vec[pend_sect_ff];
                rsp_data_ff <= {`PW_W{1'b0}};
            end else if (cmd_valid && cmd_op != `CMD_RD_NVLOCK
                         && cmd_op != `CMD_CHK_ARRAY && cmd_op != `CMD_NONE) begin
                rsp_valid_ff <= 1'b1;
                rsp_refused_ff <= nxt_refused;
                case (cmd_op)
                    `CMD_RD_MODE: rsp_data_ff <= {48'h0, mode_ff};
                    `CMD_RD_FREEZE: rsp_data_ff <= {63'h0, freeze_ff};
                    `CMD_RD_PW: rsp_data_ff <= pw_mode ? {`PW_W{1'b1}} : pw_ff;
                    `CMD_RD_VLOCK: rsp_data_ff <= {62'h0, ld_vec[sect], wp_vec[sect]};
                    default: rsp_data_ff <= {`PW_W{1'b0}};
                endcase
            end
        end
    end
endmodule

// *** testbench/sector_guard_assertions.sv ***
// Concurrent checks on the sector guard command and response ports
`include "sector_guard_consts.vh"
module sector_guard_assertions (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Command
    input wire cmd_valid,
    input wire [`CMD_W-1:0] cmd_op,
    input wire [`ADDR_W-1:0] cmd_addr,
    input wire [`PW_W-1:0] cmd_data,
    // Response
    input wire rsp_valid_ff,
    input wire [`PW_W-1:0] rsp_data_ff,
    input wire rsp_refused_ff,
    input wire array_ok_ff,
    input wire freeze_open
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Refusal and check flags only travel with a response
    property p_refuse_valid; rsp_refused_ff |-> rsp_valid_ff; endproperty
    a_refuse_valid: assert property (p_refuse_valid) else $error("refusal without response");
    property p_ok_valid; array_ok_ff |-> rsp_valid_ff && !rsp_refused_ff; endproperty
    a_ok_valid: assert property (p_ok_valid) else $error("array flag without response");
    // Freeze read answers next cycle with the level seen at the request
    property p_rd_freeze;
        cmd_valid && cmd_op == `CMD_RD_FREEZE |=>
            rsp_valid_ff && rsp_data_ff == {63'h0, $past(freeze_open)};
    endproperty
    a_rd_freeze: assert property (p_rd_freeze) else $error("freeze read wrong");
    property p_wr_freeze; cmd_valid && cmd_op == `CMD_WR_FREEZE |=> !freeze_open; endproperty
    a_wr_freeze: assert property (p_wr_freeze) else $error("freeze write did not close");
    property p_nv_frozen;
        cmd_valid && (cmd_op == `CMD_PG_NVLOCK || cmd_op == `CMD_ER_NVLOCK) && !freeze_open
            |=> rsp_refused_ff;
    endproperty
    a_nv_frozen: assert property (p_nv_frozen) else $error("lock change while frozen");
    // Only an unlock may reopen a closed freeze bit
    property p_freeze_hold;
        !freeze_open && !(cmd_valid && cmd_op == `CMD_UNLOCK) |=> !freeze_open;
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("freeze reopened");
    property p_unlock_set;
        cmd_valid && cmd_op == `CMD_UNLOCK |=> rsp_valid_ff && (rsp_refused_ff || freeze_open);
    endproperty
    a_unlock_set: assert property (p_unlock_set) else $error("unlock accepted, still frozen");
    property p_nv_read;
        cmd_valid && cmd_op == `CMD_RD_NVLOCK |=> !rsp_valid_ff ##1
            rsp_valid_ff && (rsp_data_ff[7:0] == 8'h00 || rsp_data_ff[7:0] == 8'hff);
    endproperty
    a_nv_read: assert property (p_nv_read) else $error("lock byte read wrong");
    property p_chk_delay; cmd_valid && cmd_op == `CMD_CHK_ARRAY |-> ##2 rsp_valid_ff; endproperty
    a_chk_delay: assert property (p_chk_delay) else $error("array check answer late");
    // Main scenarios
    c_unlock: cover property (cmd_valid && cmd_op == `CMD_UNLOCK ##1 !rsp_refused_ff);
    c_refused: cover property (rsp_refused_ff);
    c_array_ok: cover property (array_ok_ff);
endmodule
bind sector_password_protection sector_guard_assertions i_chk (.ref_clk(ref_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff), .rsp_refused_ff(rsp_refused_ff),
    .array_ok_ff(array_ok_ff), .freeze_open(freeze_open));

// *** testbench/host_model.sv ***
// Host controller model issuing one protection command at a time
`include "sector_guard_consts.vh"
module host_model (
    // Clock
    input wire ref_clk,
    // Command
    output logic cmd_valid,
    output logic [`CMD_W-1:0] cmd_op,
    output logic [`ADDR_W-1:0] cmd_addr,
    output logic [`PW_W-1:0] cmd_data,
    // Response
    input wire rsp_valid_ff,
    input wire [`PW_W-1:0] rsp_data_ff,
    input wire rsp_refused_ff,
    input wire array_ok_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd_op = `CMD_NONE;
        cmd_addr = 25'h0;
        cmd_data = 64'h0;
    end
    // One-cycle strobe, then wait a bounded time for the answer before the next
    task issue(input logic [3:0] op, input logic [24:0] a, input logic [63:0] d,
               output logic [63:0] q, output logic rf, output logic ok, output logic got);
        integer i;
        got = 1'b0;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        for (i = 0; i < 3 && !got; i++) begin
            #1;
            if (rsp_valid_ff === 1'b1) begin
                got = 1'b1;
                q = rsp_data_ff;
                rf = rsp_refused_ff;
                ok = array_ok_ff;
            end else begin
                @(posedge ref_clk);
            end
        end
    endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the sector guard protection logic
`include "sector_guard_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    wire cmd_valid, rsp_valid_ff, rsp_refused_ff, array_ok_ff, freeze_open;
    wire [3:0] cmd_op;
    wire [24:0] cmd_addr;
    wire [63:0] cmd_data, rsp_data_ff;
    logic [63:0] q;
    logic rf, ok, got;
    integer n_mismatch = 0, tests_run = 0, cycles = 0;
    localparam logic [63:0] PW = 64'h0123456789abcdef;
    localparam logic [24:0] R3 = 25'h060000, R4 = 25'h080000, R5 = 25'h0a0000;
    // Device and host
    sector_password_protection i_dut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid_ff(rsp_valid_ff),
        .rsp_data_ff(rsp_data_ff), .rsp_refused_ff(rsp_refused_ff), .array_ok_ff(array_ok_ff),
        .freeze_open(freeze_open));
    host_model i_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid_ff(rsp_valid_ff),
        .rsp_data_ff(rsp_data_ff), .rsp_refused_ff(rsp_refused_ff), .array_ok_ff(array_ok_ff));
    // Clock and hang guard
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task run(input logic [3:0] op, input logic [24:0] a, input logic [63:0] d);
        i_host.issue(op, a, d, q, rf, ok, got);
        check({63'h0, got}, 64'h1);
    endtask
    task do_reset(input integer n);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (n) @(posedge ref_clk);
        rst <= 1'b0;
    endtask
    // Delivered state and basic sector locking
    task t_delivered;
        run(`CMD_RD_MODE, 0, 0); check(q, 64'hffff);
        run(`CMD_RD_FREEZE, 0, 0); check(q, 64'h1);
        run(`CMD_PG_NVLOCK, R3, 0); check({63'h0, rf}, 64'h0);
        run(`CMD_RD_NVLOCK, R3, 0); check(q, 64'h00);
        run(`CMD_RD_NVLOCK, R4, 0); check(q, 64'hff);
        run(`CMD_CHK_ARRAY, 25'h070000, 0); check({63'h0, ok}, 64'h0);
        run(`CMD_CHK_ARRAY, R4, 0); check({63'h0, ok}, 64'h1);
    endtask
    // Closed freeze bit refuses lock changes
    task t_freeze;
        run(`CMD_WR_FREEZE, 0, 0);
        run(`CMD_RD_FREEZE, 0, 0); check(q, 64'h0);
        check({63'h0, freeze_open}, 64'h0);
        run(`CMD_ER_NVLOCK, 0, 0); check({63'h0, rf}, 64'h1);
        run(`CMD_RD_NVLOCK, R3, 0); check(q, 64'h00);
        run(`CMD_UNLOCK, 0, 0); check({63'h0, rf}, 64'h0);
    endtask
    // Volatile write-protect and lock-down
    task t_vlock;
        run(`CMD_WR_VLOCK, R5, 64'h1);
        run(`CMD_CHK_ARRAY, R5, 0); check({63'h0, ok}, 64'h0);
        run(`CMD_WR_VLOCK, R5, 64'h3);
        run(`CMD_WR_VLOCK, R5, 64'h0); check({63'h0, rf}, 64'h1);
        run(`CMD_CHK_ARRAY, R5, 0); check({63'h0, ok}, 64'h0);
        do_reset(2);
        run(`CMD_CHK_ARRAY, R5, 0); check({63'h0, ok}, 64'h1);
    endtask
    // Password mode selection and its lasting effects
    task t_password;
        run(`CMD_PG_PW, 0, PW);
        run(`CMD_PG_MODE, 0, 64'hfffffffffffffffb);
        run(`CMD_RD_MODE, 0, 0); check(q, 64'hfffb);
        run(`CMD_PG_MODE, 0, 64'hfffffffffffffffd); check({63'h0, rf}, 64'h1);
        run(`CMD_RD_MODE, 0, 0); check(q, 64'hfffb);
        do_reset(2);
        run(`CMD_RD_FREEZE, 0, 0); check(q, 64'h0);
        run(`CMD_RD_PW, 0, 0); check(q, 64'hffffffffffffffff);
        run(`CMD_PG_PW, 0, 64'h0); check({63'h0, rf}, 64'h1);
        run(`CMD_UNLOCK, 0, PW ^ 64'h1); check({63'h0, rf}, 64'h1);
        run(`CMD_RD_FREEZE, 0, 0); check(q, 64'h0);
        run(`CMD_UNLOCK, 0, PW); check({63'h0, rf}, 64'h0);
        run(`CMD_RD_FREEZE, 0, 0); check(q, 64'h1);
        check({63'h0, freeze_open}, 64'h1);
        run(`CMD_ER_NVLOCK, 0, 0); check({63'h0, rf}, 64'h0);
        run(`CMD_RD_NVLOCK, R3, 0); check(q, 64'hff);
        run(`CMD_WR_FREEZE, 0, 0);
    endtask
    task report_and_stop;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_delivered();
        t_freeze();
        t_vlock();
        t_password();
        report_and_stop();
    end
endmodule
